// ==== scr_pkg.sv ====
// scr_pkg: constants, types and state layout for the sequencer and sync control registers
`default_nettype none

package scr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register addresses on the host command port
	localparam logic [15:0] ADDR_SERIAL_LOW  = 16'h0000;  // serial number, low word
	localparam logic [15:0] ADDR_TEMPERATURE = 16'h0001;  // board temperature
	localparam logic [15:0] ADDR_CONTROL     = 16'h0002;  // sequencer control
	localparam logic [15:0] ADDR_STATUS      = 16'h0003;  // board status
	localparam logic [15:0] ADDR_IDENTITY    = 16'h0004;  // identity / soft reset
	localparam logic [15:0] ADDR_FW_REVISION = 16'h0005;  // revision / reload
	localparam logic [15:0] ADDR_CLK_PHASE   = 16'h0006;  // clock phase delay
	localparam logic [15:0] ADDR_SYNC_PHASE  = 16'h0007;  // sync phase delay
	localparam logic [15:0] ADDR_SELECTOR    = 16'h0008;  // source selector

	////////////////////////////////////////////////////////////////////////////
	// control register fields
	localparam int          CTRL_RUN_BIT     = 0;
	localparam int          CTRL_HOLD_BIT    = 1;
	localparam int          CTRL_RATE_LSB    = 2;
	localparam int          CTRL_PRIMARY_BIT = 4;
	localparam int          CTRL_DELAY_LSB   = 8;
	localparam logic [15:0] CTRL_RESET       = 16'h0000;
	localparam logic [15:0] CTRL_WRITE_MASK  = 16'hFF1F;  // bits 7:5 read as zero

	// selector fields; bits 3 and 4 are the live picks
	localparam int          SEL_AUTO_BIT     = 0;
	localparam int          SEL_CLK_BIT      = 1;
	localparam int          SEL_SYNC_BIT     = 2;
	localparam logic [2:0]  SEL_RESET        = 3'h1;      // automatic from the role bit

	// microcode enable bits
	localparam int          UCE_SE_CLEAR     = 0;
	localparam int          UCE_EXPO_START   = 1;
	localparam int          UCE_EXPO_STOP    = 2;
	localparam int          UCE_SYNC_LOW     = 14;
	localparam int          UCE_SYNC_HIGH    = 15;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int          CLK_PERIOD_NS    = 40;
	localparam int          INSTR_NS [4]     = '{50, 100, 200, 400};
	localparam int          MS_NS            = 1000000;
	localparam int          MS_CYCLES_DEF    = MS_NS / CLK_PERIOD_NS;
	localparam logic [4:0]  DL_FRAME_PHASES  = 5'h10;     // 8 bits, two phases each

	// instruction period in clocks, rounded up as a least time
	function automatic logic [3:0] rate_cycles(input logic [1:0] sel);
		rate_cycles = 4'((INSTR_NS[sel] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	endfunction : rate_cycles

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,  // held in reset, pc at zero
		SEQ_RUN   = 2'b01,  // stepping instructions
		SEQ_DRAIN = 2'b10   // finishing the current instruction
	} scr_seq_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} scr_req_t;

	typedef struct packed {
		logic        wr;
		logic [15:0] bits;
	} scr_uce_t;

	typedef struct packed {
		logic sclk;
		logic sdat;
		logic load;
	} scr_dl_t;

	typedef struct packed {
		logic [15:0]      ctrl;
		logic [2:0]       sel;
		logic [1:0][7:0]  phase;
		logic [9:0]       temp;
		scr_seq_t         seq_st;
		logic [3:0]       rate_cnt;
		logic             step;
		logic             pc_clear;
		logic             bus_en;
		logic [15:0]      ms_cnt;
		logic             ms_tick;
		logic             expo_en;
		logic [31:0]      expo;
		logic             expo_done;
		logic             start_flag;
		logic             sync_ff;
		logic             sync_out;
		logic             sync_oe;
		logic [7:0]       dly_cnt;
		logic             dly_busy;
		logic             sync_bit;
		logic [31:0]      rdata;
		logic             rvalid;
		logic             soft_rst;
		logic             reload_n;
		logic             clk_pick;
		logic             sync_pick;
		logic [1:0][7:0]  dl_sh;
		logic [1:0][4:0]  dl_cnt;
		logic [1:0]       dl_sclk;
		logic [1:0]       dl_sdat;
		logic [1:0]       dl_load;
	} scr_state_t;

endpackage : scr_pkg

`default_nettype wire

// ==== scr_sequencer_sync_control_regs.sv ====
// scr_sequencer_sync_control_regs: host control/status registers, sequencer pacing and sync
//
// Behaviour
// - serial read returns low 32 serial bits
// - temperature reads 10-bit signed, quarter degrees
// - run bit one lets sequencer execute
// - run cleared: finish instruction, reset, clear pc
// - hold bit freezes exposure counter
// - rate field sets 50/100/200/400ns period, rounded up to 2/3/5/10 clocks
// - each instruction takes one sequencer cycle
// - role bit makes master, enables sync out
// - sync bit: flip-flop as master, input otherwise
// - delay field sets sync emission delay, ms
// - status shows low program counter bits
// - identity read returns board type code
// - identity write performs soft reset
// - revision read returns revision times hundred
// - revision write requests firmware reload
// - clock phase byte programs clock delay line
// - sync phase byte programs sync delay line
// - selectors follow role bit after power-up
// - auto bit picks role or manual bits
// - bit1 clock, bit2 sync; one means local
// - bits 3,4 report picks in effect
// - command bits 3:0 driven by hardware
// - enable bits 14/15 drive sync low/high
`default_nettype none

module scr_sequencer_sync_control_regs
#(
	parameter int          MS_CYCLES = scr_pkg::MS_CYCLES_DEF,  // clocks per millisecond
	parameter logic [15:0] BOARD_ID  = 16'h0A5C,                // arbitrary value
	parameter logic [15:0] FW_REV    = 16'h01F4                 // arbitrary value
)(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire scr_pkg::scr_req_t reg_req,
	output var  logic [31:0]      reg_rdata,
	output var  logic             reg_rvalid,
	input  wire logic [47:0]      serial_number,
	input  wire logic [9:0]       temp_code,
	input  wire logic             temp_valid,
	input  wire logic [11:0]      seq_pc,
	input  wire scr_pkg::scr_uce_t microcode_enable_bits,
	input  wire logic             start_exposure,
	input  wire logic [31:0]      integration_time,
	input  wire logic             sync_in,
	output var  logic             seq_step,
	output var  logic             seq_pc_clear,
	output var  logic             seq_bus_enable,
	output var  logic [3:0]       cmd_hw_bits,
	output var  logic [31:0]      exposure_time_counter,
	output var  logic             sync_out,
	output var  logic             sync_out_en,
	output var  logic             sysclk_pick_now,
	output var  logic             sync_pick_now,
	output var  logic             soft_reset_pulse,
	output var  logic             reload_n,
	output var  scr_pkg::scr_dl_t clk_delay_line,
	output var  scr_pkg::scr_dl_t sync_delay_line
);
	import scr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// one access at one address; shared by the read and write paths
	function automatic logic hit(input scr_req_t r, input logic [15:0] a, input logic wr);
		hit = (r.addr == a) && (wr ? r.wr : r.rd);
	endfunction : hit

	scr_state_t s;      // registered state
	scr_state_t n;      // next state
	logic [3:0] period; // current instruction period in clocks
	logic       primary;// chassis role, one for master

	assign period  = rate_cycles(s.ctrl[CTRL_RATE_LSB +: 2]);
	assign primary = s.ctrl[CTRL_PRIMARY_BIT];

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb
	begin
		n          = s;
		n.step     = 1'b0;
		n.pc_clear = 1'b0;
		n.rvalid   = 1'b0;
		n.soft_rst = 1'b0;
		n.ms_tick  = 1'b0;
		n.dl_load  = 2'b00;

		// temperature sampled whenever the sensor offers a value
		if (temp_valid)
			n.temp = temp_code;

		// host writes
		if (hit(reg_req, ADDR_CONTROL, 1'b1))
			n.ctrl = reg_req.wdata & CTRL_WRITE_MASK;
		if (hit(reg_req, ADDR_SELECTOR, 1'b1))
			n.sel = reg_req.wdata[2:0];
		if (hit(reg_req, ADDR_FW_REVISION, 1'b1))
			n.reload_n = 1'b0; // latched: the reload takes the whole device down

		// phase writes restart the serial frame even mid-transfer
		for (int i = 0; i < 2; i++)
		begin
			if (hit(reg_req, i == 0 ? ADDR_CLK_PHASE : ADDR_SYNC_PHASE, 1'b1))
			begin
				n.phase[i]   = reg_req.wdata[7:0];
				n.dl_sh[i]   = reg_req.wdata[7:0];
				n.dl_cnt[i]  = DL_FRAME_PHASES;
				n.dl_sclk[i] = 1'b0;
			end
			else if (s.dl_cnt[i] != 5'h00)
			begin
				n.dl_cnt[i] = s.dl_cnt[i] - 5'h01;
				if (!s.dl_cnt[i][0])
				begin
					// setup phase: clock low, msb on the data line
					n.dl_sclk[i] = 1'b0;
					n.dl_sdat[i] = s.dl_sh[i][7];
				end
				else
				begin
					// rising phase: line samples, move to next bit
					n.dl_sclk[i] = 1'b1;
					n.dl_sh[i]   = {s.dl_sh[i][6:0], 1'b0};
				end
				n.dl_load[i] = (s.dl_cnt[i] == 5'h01); // latch code after the last bit
			end
		end

		// millisecond timebase shared by exposure counter and sync delay
		if (s.ms_cnt == 16'(MS_CYCLES - 1))
		begin
			n.ms_cnt  = 16'h0000;
			n.ms_tick = 1'b1;
		end
		else
			n.ms_cnt = s.ms_cnt + 16'h0001;

		// sequencer pacing: one step per instruction period
		unique case (s.seq_st)
			SEQ_IDLE:
			begin
				n.rate_cnt = 4'h0;
				n.bus_en   = 1'b0;
				if (s.ctrl[CTRL_RUN_BIT])
				begin
					n.seq_st = SEQ_RUN;
					n.bus_en = 1'b1;
				end
			end
			SEQ_RUN, SEQ_DRAIN:
			begin
				if (s.rate_cnt >= period - 4'h1)
				begin
					// end of an instruction: exactly one per period
					n.rate_cnt = 4'h0;
					n.step     = 1'b1;
					if (s.seq_st == SEQ_DRAIN)
					begin
						n.seq_st   = SEQ_IDLE;
						n.pc_clear = 1'b1;
						n.bus_en   = 1'b0;     // selects and requests masked
					end
				end
				else
					n.rate_cnt = s.rate_cnt + 4'h1;
				if (s.seq_st == SEQ_RUN && !s.ctrl[CTRL_RUN_BIT])
					n.seq_st = (n.seq_st == SEQ_IDLE) ? SEQ_IDLE : SEQ_DRAIN;
				else if (s.seq_st == SEQ_DRAIN && s.ctrl[CTRL_RUN_BIT] && !n.pc_clear)
					n.seq_st = SEQ_RUN;
			end
		endcase

		// exposure counter: microcode starts and stops it, host may hold it
		if (microcode_enable_bits.wr && microcode_enable_bits.bits[UCE_EXPO_START])
		begin
			n.expo_en = 1'b1;
			n.expo    = 32'h0000_0000;
		end
		else if (microcode_enable_bits.wr && microcode_enable_bits.bits[UCE_EXPO_STOP])
			n.expo_en = 1'b0;
		else if (s.expo_en && s.ms_tick && !s.ctrl[CTRL_HOLD_BIT])
			n.expo = s.expo + 32'h0000_0001; // held while the hold bit is one
		n.expo_done = (n.expo >= integration_time);

		// start exposure flag: a set in the same cycle as a clear wins
		if (microcode_enable_bits.wr && microcode_enable_bits.bits[UCE_SE_CLEAR])
			n.start_flag = 1'b0;
		if (start_exposure)
			n.start_flag = 1'b1;

		// sync flip-flop under microcode control; high wins a double command
		if (microcode_enable_bits.wr && microcode_enable_bits.bits[UCE_SYNC_LOW])
			n.sync_ff = 1'b0;
		if (microcode_enable_bits.wr && microcode_enable_bits.bits[UCE_SYNC_HIGH])
			n.sync_ff = 1'b1;

		// emitted sync: rises at once, falls after the programmed ms
		if (n.sync_ff && !s.sync_ff)
		begin
			n.sync_out = 1'b1;
			n.dly_busy = 1'b0;
		end
		else if (!n.sync_ff && s.sync_ff)
		begin
			if (s.ctrl[CTRL_DELAY_LSB +: 8] == 8'h00)
				n.sync_out = 1'b0;
			else
			begin
				n.dly_cnt  = s.ctrl[CTRL_DELAY_LSB +: 8];
				n.dly_busy = 1'b1;
			end
		end
		else if (s.dly_busy && s.ms_tick)
		begin
			// first tick comes up to one ms early: timebase is free running
			n.dly_cnt = s.dly_cnt - 8'h01;
			if (s.dly_cnt == 8'h01)
			begin
				n.dly_busy = 1'b0;
				n.sync_out = 1'b0;
			end
		end
		n.sync_oe = primary; // output driven only as master

		// sync condition bit: flip-flop as master, cable as slave
		n.sync_bit = primary ? s.sync_ff : sync_in;

		// source picks, automatic from the role or manual
		if (s.sel[SEL_AUTO_BIT])
		begin
			n.clk_pick  = primary;
			n.sync_pick = primary;
		end
		else
		begin
			n.clk_pick  = s.sel[SEL_CLK_BIT];
			n.sync_pick = s.sel[SEL_SYNC_BIT];
		end

		// host reads: one cycle later, unmapped reads zero
		if (reg_req.rd)
		begin
			n.rvalid = 1'b1;
			n.rdata  = 32'h0000_0000;
			if (hit(reg_req, ADDR_SERIAL_LOW, 1'b0))
				n.rdata = serial_number[31:0];
			if (hit(reg_req, ADDR_TEMPERATURE, 1'b0))
				n.rdata = {22'h000000, s.temp};
			if (hit(reg_req, ADDR_CONTROL, 1'b0))
				n.rdata = {16'h0000, s.ctrl};
			if (hit(reg_req, ADDR_STATUS, 1'b0))
				n.rdata = {16'h0000, s.bus_en, s.sync_bit, s.expo_done, s.start_flag,
					seq_pc};
			if (hit(reg_req, ADDR_IDENTITY, 1'b0))
				n.rdata = {16'h0000, BOARD_ID};
			if (hit(reg_req, ADDR_FW_REVISION, 1'b0))
				n.rdata = {16'h0000, FW_REV};
			if (hit(reg_req, ADDR_SELECTOR, 1'b0))
				n.rdata = {27'h0000000, s.sync_pick, s.clk_pick, s.sel};
		end

		// soft reset: sequencer halted at once, control cleared
		if (hit(reg_req, ADDR_IDENTITY, 1'b1))
		begin
			n.soft_rst = 1'b1;       // clock enable and test counter clear outside
			n.ctrl     = CTRL_RESET;
			n.seq_st   = SEQ_IDLE;
			n.bus_en   = 1'b0;       // bus released
			n.pc_clear = 1'b1;
			n.rate_cnt = 4'h0;
			n.step     = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s          <= '0;
			s.ctrl     <= CTRL_RESET;
			s.sel      <= SEL_RESET;
			s.seq_st   <= SEQ_IDLE;
			s.reload_n <= 1'b1;
		end
		else
			s <= n;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from state
	assign reg_rdata             = s.rdata;
	assign reg_rvalid            = s.rvalid;
	assign seq_step              = s.step;
	assign seq_pc_clear          = s.pc_clear;
	assign seq_bus_enable        = s.bus_en;
	assign cmd_hw_bits           = {s.start_flag, s.expo_done, s.sync_bit, 1'b1};
	assign exposure_time_counter = s.expo;
	assign sync_out              = s.sync_out;
	assign sync_out_en           = s.sync_oe;
	assign sysclk_pick_now       = s.clk_pick;
	assign sync_pick_now         = s.sync_pick;
	assign soft_reset_pulse      = s.soft_rst;
	assign reload_n              = s.reload_n;
	assign clk_delay_line        = '{sclk: s.dl_sclk[0], sdat: s.dl_sdat[0], load: s.dl_load[0]};
	assign sync_delay_line       = '{sclk: s.dl_sclk[1], sdat: s.dl_sdat[1], load: s.dl_load[1]};

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	step_period_a: assert property (
		s.step && s.seq_st == SEQ_RUN && s.ctrl[3:2] == 2'b00 && !reg_req.wr
		|=> !s.step ##1 (s.step || s.seq_st == SEQ_IDLE))
		else $error("instruction period at fastest rate is not two clocks");
	halt_clears_pc_a: assert property (
		s.seq_st == SEQ_DRAIN && !s.ctrl[CTRL_RUN_BIT] |-> ##[0:10] s.pc_clear)
		else $error("halt did not clear the program counter in time");
	hold_freezes_count_a: assert property (
		s.ctrl[CTRL_HOLD_BIT] && !microcode_enable_bits.wr |=> s.expo == $past(s.expo))
		else $error("exposure counter moved while held");
	slave_sync_bit_a: assert property (
		!primary |=> s.sync_bit == $past(sync_in))
		else $error("slave sync bit does not follow the cable");
	auto_pick_a: assert property (
		s.sel[SEL_AUTO_BIT] |=> s.clk_pick == $past(primary) && s.sync_pick == $past(primary))
		else $error("automatic pick does not follow the role");
	reload_latch_a: assert property (
		!s.reload_n |=> !s.reload_n)
		else $error("reload request released");
	soft_reset_halt_a: assert property (
		hit(reg_req, ADDR_IDENTITY, 1'b1)
		|=> s.ctrl == CTRL_RESET && s.soft_rst && s.seq_st == SEQ_IDLE && !s.bus_en)
		else $error("soft reset did not halt the sequencer");
	sync_zero_delay_a: assert property (
		$fell(s.sync_ff) && $past(s.ctrl[15:8]) == 8'h00 |-> !s.sync_out)
		else $error("zero delay sync not emitted with the flip-flop");
	phase_frame_a: assert property (
		hit(reg_req, ADDR_CLK_PHASE, 1'b1) |=> s.dl_cnt[0] == DL_FRAME_PHASES
		##16 (s.dl_load[0] || s.dl_cnt[0] != 5'h00)) // a later write restarts the frame
		else $error("clock phase write did not run a full frame");
	reserved_zero_a: assert property (
		s.ctrl[7:5] == 3'h0)
		else $error("reserved control bits set");

	step_seen_c:  cover property (s.seq_st == SEQ_RUN ##1 s.step);
	halt_seen_c:  cover property (s.seq_st == SEQ_DRAIN ##[1:10] s.pc_clear);
	frame_done_c: cover property (s.dl_load[1]);
	sync_emit_c:  cover property (s.sync_oe && $fell(s.sync_out));

endmodule : scr_sequencer_sync_control_regs

`default_nettype wire

// ==== scr_host_model.sv ====
// scr_host_model: host node issuing register commands over the link
`default_nettype none

module scr_host_model (
	input  wire logic              clk,     // system clock
	output var  scr_pkg::scr_req_t req,     // command strobes, address, data
	input  wire logic [31:0]       rdata,   // read data from the board
	input  wire logic              rvalid   // read answer strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	import scr_pkg::*;

	// idle until the first command
	initial req = '0;

	////////////////////////////////////////////////////////////////////////////
	// one-cycle write strobe; the address and data lines are scrambled afterwards
	// so that a design sampling them outside the strobe cannot pass by luck
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr

	// one-cycle read strobe; the answer stands in the cycle after the taken edge
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
		// no answer strobe gives unknown data, which never matches
		d = (rvalid === 1'b1) ? rdata : 32'hX;
	endtask : rd

endmodule : scr_host_model

`default_nettype wire

// ==== scr_tb.sv ====
// tb: self-checking bench for the sequencer and sync control registers
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import scr_pkg::*;

	localparam int          MS    = 4;         // short millisecond for simulation
	localparam logic [15:0] ID_CD = 16'h0B3D;  // arbitrary value
	localparam logic [15:0] FW_CD = 16'h01F4;  // revision 5.00 times one hundred

	typedef struct {
		logic        dw;    // write before the read
		logic [15:0] wa;    // write address
		logic [15:0] wd;    // write data
		logic [15:0] ra;    // read address
		logic [31:0] mask;  // bits compared
		logic [31:0] exp;   // expected read
	} scr_row_t;

	logic clk, reset, temp_valid, start_exp, sync_in, rvalid;
	logic step, pc_clear, bus_en, sync_out, sync_oe, clk_pick, sync_pick, soft_pulse, reload_n;
	logic [31:0] rdata, expo, itime, v;
	logic [47:0] serial;
	logic [11:0] pc;
	logic [9:0]  temp;
	logic [3:0]  cmd;
	scr_req_t    req;
	scr_uce_t    uce;
	scr_dl_t     dl_clk, dl_sync;
	int          err_count = 0, n_tests = 0, n_step = 0, k, g, m;
	int          ins_ns [4] = '{50, 100, 200, 400};  // instruction periods, ns
	scr_row_t    rows [12] = '{
		'{0, 16'h0, 16'h0000, 16'h0, 32'hFFFFFFFF, 32'h56789ABC},
		'{0, 16'h0, 16'h0000, 16'h1, 32'h000003FF, 32'h000003F6},
		'{1, 16'h2, 16'hABE0, 16'h2, 32'h0000FFFF, 32'h0000AB00},
		'{1, 16'h2, 16'h0010, 16'h8, 32'h0000001F, 32'h00000019},
		'{1, 16'h8, 16'h0002, 16'h8, 32'h0000001F, 32'h0000000A},
		'{1, 16'h8, 16'h0004, 16'h8, 32'h0000001F, 32'h00000014},
		'{1, 16'h8, 16'h0001, 16'h8, 32'h0000001F, 32'h00000019},
		'{1, 16'h2, 16'h0000, 16'h8, 32'h0000001F, 32'h00000001},
		'{0, 16'h0, 16'h0000, 16'h3, 32'h00000FFF, 32'h00000ABC},
		'{0, 16'h0, 16'h0000, 16'h4, 32'h0000FFFF, {16'h0, ID_CD}},
		'{0, 16'h0, 16'h0000, 16'h9, 32'hFFFFFFFF, 32'h00000000},
		'{1, 16'h0, 16'hFFFF, 16'h0, 32'hFFFFFFFF, 32'h56789ABC}};

	////////////////////////////////////////////////////////////////////////////
	// design, host partner, clock and step counter
	scr_sequencer_sync_control_regs #(.MS_CYCLES(MS), .BOARD_ID(ID_CD), .FW_REV(FW_CD)) DUT (
		.clk(clk), .reset(reset), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.serial_number(serial), .temp_code(temp), .temp_valid(temp_valid), .seq_pc(pc),
		.microcode_enable_bits(uce), .start_exposure(start_exp), .integration_time(itime),
		.sync_in(sync_in), .seq_step(step), .seq_pc_clear(pc_clear), .seq_bus_enable(bus_en),
		.cmd_hw_bits(cmd), .exposure_time_counter(expo), .sync_out(sync_out),
		.sync_out_en(sync_oe), .sysclk_pick_now(clk_pick), .sync_pick_now(sync_pick),
		.soft_reset_pulse(soft_pulse), .reload_n(reload_n), .clk_delay_line(dl_clk),
		.sync_delay_line(dl_sync));
	scr_host_model host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

	always #20 clk = ~clk;
	// steps counted here so idle spans can be checked for silence
	always @(posedge clk)
		if (step === 1'b1)
			n_step <= n_step + 1;

	////////////////////////////////////////////////////////////////////////////
	// helpers: all waits end on a falling edge, where stimulus changes
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic rd_chk(input logic [15:0] a, input logic [31:0] mk, input logic [31:0] e);
		logic [31:0] d;
		host.rd(a, d);
		chk(d & mk, e, "register read");
	endtask : rd_chk

	// microcode enable write, one cycle
	task automatic pulse_uce(input logic [15:0] b);
		uce <= '{wr: 1'b1, bits: b};
		cyc(1);
		uce <= '{wr: 1'b0, bits: 16'h0000};
	endtask : pulse_uce

	// gap in clocks between two sequencer steps
	task automatic step_gap(output int n);
		int w;
		for (w = 0; w < 40 && step !== 1'b1; w++) cyc(1);
		n = 0;
		do begin cyc(1); n++; end while (step !== 1'b1 && n < 40);
	endtask : step_gap

	// collects the serial frame of one delay line: bit kept while the clock is low
	task automatic dl_chk(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] sh;
		logic       pv, sd, ld;
		scr_dl_t    l;
		host.wr(a, {8'h00, e});
		{sh, pv, sd, ld} = {8'h00, 3'b100};
		for (int i = 0; i < 24 && !ld; i++)
		begin
			cyc(1);
			l = (a == ADDR_CLK_PHASE) ? dl_clk : dl_sync;
			if (l.sclk === 1'b1 && pv === 1'b0)
				sh = {sh[6:0], sd};
			sd = l.sdat;
			pv = l.sclk;
			ld = (l.load === 1'b1);
		end
		chk(32'(sh), 32'(e), "delay line byte");
		chk(32'(ld), 32'h1, "delay line load");
	endtask : dl_chk

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	// the whole run needs a few hundred cycles; this cuts a hang short
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		finish_test();
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{clk, reset, temp_valid, start_exp, sync_in} = 5'b01100;
		{serial, pc, temp, itime} = {48'h123456789ABC, 12'hABC, 10'h3F6, 32'd3};
		uce = '{wr: 1'b0, bits: 16'h0000};
		cyc(5);
		reset = 1'b0;
		cyc(2);
		// reset values
		rd_chk(ADDR_CONTROL, 32'hFFFF, 32'h0);
		rd_chk(ADDR_SELECTOR, 32'h1F, 32'h01);
		chk(32'(cmd), 32'h1, "command bits idle");
		chk(32'(reload_n), 32'h1, "reload idle");
		chk(32'(n_step), 32'h0, "no steps idle");
		chk(32'(bus_en), 32'h0, "bus idle");
		$display("test reset done");
		// table of register reads
		foreach (rows[i])
		begin
			if (rows[i].dw)
				host.wr(rows[i].wa, rows[i].wd);
			cyc(2);
			rd_chk(rows[i].ra, rows[i].mask, rows[i].exp);
		end
		rd_chk(ADDR_FW_REVISION, 32'hFFFF, {16'h0, FW_CD});
		temp = 10'h005;
		cyc(2);
		rd_chk(ADDR_TEMPERATURE, 32'h3FF, 32'h005);
		$display("test table done");
		// every rate, measured on the second gap after the change
		for (int r = 0; r < 4; r++)
		begin
			host.wr(ADDR_CONTROL, 16'h0001 | 16'(r << 2));
			step_gap(g);
			step_gap(g);
			chk(32'(g), 32'((ins_ns[r] + 39) / 40), "instruction period");
			chk(32'(bus_en), 32'h1, "bus while running");
		end
		host.wr(ADDR_CONTROL, 16'h0000);
		for (k = 0; k < 14 && pc_clear !== 1'b1; k++) cyc(1);
		chk(32'(pc_clear), 32'h1, "pc clear on halt");
		cyc(1);
		chk(32'(bus_en), 32'h0, "bus released on halt");
		m = n_step;
		cyc(20);
		chk(32'(n_step), 32'(m), "no steps halted");
		$display("test sequencer done");
		// exposure counter, hold bit, command flags
		pulse_uce(16'h0002);
		cyc(2);
		chk(32'(cmd[2]), 32'h0, "exposure not done");
		cyc(5 * MS);
		chk(32'(cmd[2]), 32'h1, "exposure done");
		host.wr(ADDR_CONTROL, 16'h0002);
		cyc(2);
		v = expo;
		cyc(6 * MS);
		chk(expo, v, "counter held");
		host.wr(ADDR_CONTROL, 16'h0000);
		cyc(3 * MS);
		chk(32'(expo > v), 32'h1, "counter resumed");
		pulse_uce(16'h0004);
		v = expo;
		cyc(3 * MS);
		chk(expo, v, "counter stopped");
		start_exp = 1'b1;
		cyc(1);
		start_exp = 1'b0;
		cyc(2);
		chk(32'(cmd[3]), 32'h1, "start flag set");
		pulse_uce(16'h0001);
		cyc(2);
		chk(32'(cmd[3]), 32'h0, "start flag cleared");
		$display("test exposure done");
		// master with a 2 ms emission delay, then slave
		host.wr(ADDR_CONTROL, 16'h0210);
		cyc(2);
		chk(32'({sync_oe, clk_pick, sync_pick}), 32'h7, "master outputs");
		pulse_uce(16'h8000);
		cyc(1);
		chk(32'(sync_out), 32'h1, "sync high");
		cyc(2);
		chk(32'(cmd[1]), 32'h1, "sync bit master");
		sync_in = 1'b1;
		pulse_uce(16'h4000);
		cyc(2);
		chk(32'(sync_out), 32'h1, "sync delayed");
		cyc(10);
		chk(32'(sync_out), 32'h0, "sync emitted");
		chk(32'(cmd[1]), 32'h0, "sync bit from ff");
		host.wr(ADDR_CONTROL, 16'h0010);
		pulse_uce(16'h8000);
		cyc(1);
		pulse_uce(16'h4000);
		chk(32'(sync_out), 32'h0, "sync at once, no delay");
		host.wr(ADDR_CONTROL, 16'h0000);
		cyc(3);
		chk(32'({sync_oe, cmd[1]}), 32'h1, "slave follows input");
		sync_in = 1'b0;
		cyc(3);
		chk(32'(cmd[1]), 32'h0, "slave input low");
		$display("test sync done");
		// delay lines, one restarted in mid-frame
		dl_chk(ADDR_CLK_PHASE, 8'hA5);
		dl_chk(ADDR_SYNC_PHASE, 8'h3C);
		host.wr(ADDR_CLK_PHASE, 16'h00FF);
		cyc(5);
		dl_chk(ADDR_CLK_PHASE, 8'h81);
		$display("test delay lines done");
		// soft reset while running, then hard reset request
		host.wr(ADDR_CONTROL, 16'h0001);
		cyc(4);
		host.wr(ADDR_IDENTITY, 16'h0000);
		chk(32'(soft_pulse), 32'h1, "soft reset pulse");
		for (k = 0; k < 3 && pc_clear !== 1'b1; k++) cyc(1);
		chk(32'(pc_clear), 32'h1, "pc clear soft");
		cyc(1);
		chk(32'(bus_en), 32'h0, "bus released soft");
		rd_chk(ADDR_CONTROL, 32'hFFFF, 32'h0);
		host.wr(ADDR_FW_REVISION, 16'h0000);
		cyc(1);
		chk(32'(reload_n), 32'h0, "reload requested");
		$display("test resets done");
		// reset again in mid-run: everything back to its power-up values
		host.wr(ADDR_CONTROL, 16'h0011);
		cyc(4);
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		cyc(2);
		chk(32'({reload_n, bus_en, sync_oe, clk_pick}), 32'h8, "mid-run reset");
		rd_chk(ADDR_CONTROL, 32'hFFFF, 32'h0);
		rd_chk(ADDR_SELECTOR, 32'h1F, 32'h01);
		$display("test mid-run reset done");
		finish_test();
	end

endmodule : tb

`default_nettype wire
